/* File: design/dmbs_pkg.sv */
/*
 * constants for the data-move and bank-select execution block:
 * opcode fields, special data addresses and reset values.
 * assumes an 8-bit data space of 256 locations.
 */
package dmbs_pkg;
   // instruction word fields
   localparam int INSTR_W = 16;
   localparam int DATA_W = 8;
   localparam int DST_W = 5;
   localparam int NIB_W = 4;
   localparam logic [2:0] COPY_OPC = 3'h3;
   localparam int COPY_OPC_MSB = 15;
   localparam int COPY_OPC_LSB = 13;
   localparam int DST_MSB = 12;
   localparam int DST_LSB = 8;
   localparam int SRC_MSB = 7;
   localparam int SRC_LSB = 0;
   localparam logic [7:0] BANK_OPC = 8'hb8;
   localparam int BANK_OPC_MSB = 15;
   localparam int BANK_OPC_LSB = 8;
   localparam int LIT_MSB = 3;
   localparam int LIT_LSB = 0;
   // special data-space locations
   localparam logic [7:0] IND0_ADDR = 8'h00;
   localparam logic [7:0] IND1_ADDR = 8'h08;
   localparam logic [7:0] BANK_ADDR = 8'h0f;
   // reset values
   localparam logic [7:0] BANK_RST = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
endpackage

/* File: design/addr_resolve_if.sv */
/*
 * carries one operand address to the indirect resolver and back.
 * assumes both ends run on the core clock.
 */
`timescale 1ns/1ps
interface addr_resolve_if;
   logic [7:0] raw_addr;
   logic [7:0] ptr0;
   logic [7:0] ptr1;
   logic [7:0] eff_addr;
   logic is_indirect;

   modport requester (
      output raw_addr,
      output ptr0,
      output ptr1,
      input eff_addr,
      input is_indirect
   );
   modport resolver (
      input raw_addr,
      input ptr0,
      input ptr1,
      output eff_addr,
      output is_indirect
   );
endinterface

/* File: design/addr_resolver.sv */
/*
 * indirect operand resolver: an access to either indirect location
 * is steered to the address held in its pointer.
 * assumes pointers come from core logic on the same clock.
 */
`timescale 1ns/1ps
module addr_resolver (
   // operand in, address out
   addr_resolve_if.resolver rif
);
   wire hit0;
   wire hit1;

   // pointer select; purely combinational so the move stays one cycle
   assign hit0 = (rif.raw_addr == dmbs_pkg::IND0_ADDR);
   assign hit1 = (rif.raw_addr == dmbs_pkg::IND1_ADDR);
   assign rif.is_indirect = hit0 | hit1;
   assign rif.eff_addr = hit0 ? rif.ptr0 :
                         hit1 ? rif.ptr1 : rif.raw_addr;
endmodule

/* File: design/data_move_bank_select_exec.sv */
/*
 * execution of the file-to-peripheral copy and the bank low-nibble load.
 * assumes a data memory with combinational read on the core clock, and
 * that the core presents at most one instruction per cycle.
 */
// Overview of operation
// - copy reads source byte, writes same value to destination, source untouched
// - source operand addresses any of 256 locations, working register included
// - destination is a 5-bit field, locations 0 to 31
// - both operands resolve through indirect pointers when selected
// - bank load puts 4-bit literal in bits 3:0, bits 7:4 kept
// - reduced variant: bank register upper four bits read zero
`timescale 1ns/1ps
module data_move_bank_select_exec #(
   parameter bit REDUCED_BANK = 1'b0
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // instruction stream
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   // indirect pointers
   input wire logic [7:0] i_ptr0,
   input wire logic [7:0] i_ptr1,
   // data memory read
   output logic [7:0] o_rd_addr,
   input wire logic [7:0] i_rd_data,
   // data memory write
   output logic o_wr_en,
   output logic [7:0] o_wr_addr,
   output logic [7:0] o_wr_data,
   // bank selection register view
   output logic [7:0] o_bank_select
);
   logic [7:0] bank_select_ff;
   logic [7:0] nxt_bank_select;
   logic wr_en_ff;
   logic [7:0] wr_addr_ff;
   logic [7:0] wr_data_ff;
   wire is_copy;
   wire is_bank_load;
   wire [7:0] src_field;
   wire [4:0] dst_field;
   wire [3:0] lit;
   wire [7:0] bank_view;
   wire [7:0] mem_data;
   wire [7:0] src_data;
   wire bank_hit_wr;
   wire fwd_hit;

   addr_resolve_if src_if ();
   addr_resolve_if dst_if ();

   ////////////////////////////////////////////////////////////////////
   // decode
   assign is_copy = i_instr_valid &&
      (i_instr[dmbs_pkg::COPY_OPC_MSB:dmbs_pkg::COPY_OPC_LSB]
       == dmbs_pkg::COPY_OPC);
   assign is_bank_load = i_instr_valid &&
      (i_instr[dmbs_pkg::BANK_OPC_MSB:dmbs_pkg::BANK_OPC_LSB]
       == dmbs_pkg::BANK_OPC);
   assign src_field = i_instr[dmbs_pkg::SRC_MSB:dmbs_pkg::SRC_LSB];
   assign dst_field = i_instr[dmbs_pkg::DST_MSB:dmbs_pkg::DST_LSB];
   assign lit = i_instr[dmbs_pkg::LIT_MSB:dmbs_pkg::LIT_LSB];

   ////////////////////////////////////////////////////////////////////
   // operand resolution, same resolver for both sides
   assign src_if.raw_addr = src_field;
   assign src_if.ptr0 = i_ptr0;
   assign src_if.ptr1 = i_ptr1;
   assign dst_if.raw_addr = {3'h0, dst_field};
   assign dst_if.ptr0 = i_ptr0;
   assign dst_if.ptr1 = i_ptr1;

   addr_resolver u_src_res (
      .rif (src_if.resolver)
   );
   addr_resolver u_dst_res (
      .rif (dst_if.resolver)
   );

   ////////////////////////////////////////////////////////////////////
   // source read; forwarding covers a copy that reads last cycle's write
   assign o_rd_addr = src_if.eff_addr;
   assign bank_view = REDUCED_BANK ? {4'h0, bank_select_ff[3:0]} :
                      bank_select_ff;
   assign fwd_hit = wr_en_ff &&
      (wr_addr_ff == src_if.eff_addr);
   assign mem_data = fwd_hit ? wr_data_ff : i_rd_data;
   // the bank view wins over forwarding: a forwarded byte still holds
   // the stored upper nibble, which the reduced variant must hide
   assign src_data = (src_if.eff_addr == dmbs_pkg::BANK_ADDR) ?
                     bank_view : mem_data;

   ////////////////////////////////////////////////////////////////////
   // bank register next value; a copy into it counts as well
   assign bank_hit_wr = is_copy &&
      (dst_if.eff_addr == dmbs_pkg::BANK_ADDR);
   assign nxt_bank_select =
      is_bank_load ? {bank_select_ff[7:4], lit} :
      bank_hit_wr ? src_data : bank_select_ff;
   assign o_bank_select = bank_view;

   // bank register
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bank_select_ff <= dmbs_pkg::BANK_RST;
      end else begin
         bank_select_ff <= nxt_bank_select;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // write port, one edge after decode; no status path exists at all
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_en_ff <= 1'b0;
         wr_addr_ff <= dmbs_pkg::ADDR_RST;
         wr_data_ff <= dmbs_pkg::DATA_RST;
      end else begin
         wr_en_ff <= is_copy;
         if (is_copy) begin
            wr_addr_ff <= dst_if.eff_addr;
            wr_data_ff <= src_data;
         end
      end
   end

   assign o_wr_en = wr_en_ff;
   assign o_wr_addr = wr_addr_ff;
   assign o_wr_data = wr_data_ff;

   ////////////////////////////////////////////////////////////////////
   // checks
   a_copy_value_moved: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy |=> o_wr_data == $past(src_data))
      else $error("copy wrote a value other than the source");

   a_src_direct_addr: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy && !src_if.is_indirect |-> o_rd_addr == src_field)
      else $error("source address not taken from operand");

   a_dst_low_range: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy && !dst_if.is_indirect
      |=> o_wr_addr == {3'h0, $past(dst_field)})
      else $error("destination outside low 32 locations");

   a_src_indirect_ptr: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy && src_field == dmbs_pkg::IND1_ADDR
      |-> o_rd_addr == i_ptr1)
      else $error("indirect source not resolved");

   a_dst_indirect_ptr: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy && dst_field == dmbs_pkg::IND0_ADDR[4:0]
      |=> o_wr_addr == $past(i_ptr0))
      else $error("indirect destination not resolved");

   a_bank_low_load: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_bank_load |=> bank_select_ff[3:0] == $past(lit)
      && bank_select_ff[7:4] == $past(bank_select_ff[7:4]))
      else $error("bank low-nibble load wrong");

   a_bank_upper_zero: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      REDUCED_BANK |-> o_bank_select[7:4] == 4'h0)
      else $error("reduced bank register upper bits not zero");

   a_copy_one_cycle: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy ##1 !is_copy |=> !o_wr_en)
      else $error("copy write lasted more than one cycle");

   a_no_stray_write: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      !is_copy |=> !o_wr_en)
      else $error("write without a copy instruction");

   a_copy_write_pulse: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy |=> o_wr_en)
      else $error("copy produced no write");

   // the copied byte is checked per source kind, since forwarding and
   // the bank view are where a wrong byte would slip through
   a_copy_mem_data: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy && o_rd_addr != dmbs_pkg::BANK_ADDR
      && !(o_wr_en && o_wr_addr == o_rd_addr)
      |=> o_wr_data == $past(i_rd_data))
      else $error("copy did not move the memory byte");

   a_copy_fwd_data: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy && o_rd_addr != dmbs_pkg::BANK_ADDR
      && o_wr_en && o_wr_addr == o_rd_addr
      |=> o_wr_data == $past(o_wr_data))
      else $error("copy missed the byte written just before");

   a_copy_bank_src: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy && o_rd_addr == dmbs_pkg::BANK_ADDR
      |=> o_wr_data == $past(o_bank_select))
      else $error("copy from bank register saw hidden bits");

   a_bank_kept: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      !is_bank_load
      && !(is_copy && dst_if.eff_addr == dmbs_pkg::BANK_ADDR)
      |=> $stable(bank_select_ff))
      else $error("bank register changed without a write");

   a_src_ptr0_used: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy && src_field == dmbs_pkg::IND0_ADDR
      |-> o_rd_addr == i_ptr0)
      else $error("indirect source via pointer 0 not resolved");

   a_dst_ptr1_used: assert property (
      @(posedge i_clock) disable iff (i_sys_rst)
      is_copy && dst_field == dmbs_pkg::IND1_ADDR[4:0]
      |=> o_wr_addr == $past(i_ptr1))
      else $error("indirect destination via pointer 1 not resolved");
endmodule

/* File: sim/data_move_bank_select_exec_test.sv */
/*
 * self-checking bench for the copy and bank low-nibble load block.
 * assumes a combinational data memory modelled here and a 4 ns clock.
 */
`timescale 1ns/1ps
module data_move_bank_select_exec_test;
   logic i_clock, i_sys_rst, i_instr_valid, o_wr_en;
   logic [15:0] i_instr;
   logic [7:0] i_ptr0, i_ptr1, i_rd_data, o_rd_addr, o_wr_addr, o_wr_data;
   logic [7:0] o_bank_select, rd_addr_r, rd_data_r, bank_r, wr_data_r;
   logic [7:0] mem [256];
   int n_errors, checks_done, cycles;

   ////////////////////////////////////////////////////////////////////
   // full-width bank and reduced bank side by side
   data_move_bank_select_exec #(.REDUCED_BANK(1'b0)) dut_u (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .i_ptr0(i_ptr0), .i_ptr1(i_ptr1),
      .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data), .o_wr_en(o_wr_en),
      .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
      .o_bank_select(o_bank_select));
   data_move_bank_select_exec #(.REDUCED_BANK(1'b1)) dut_r (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .i_ptr0(i_ptr0), .i_ptr1(i_ptr1),
      .o_rd_addr(rd_addr_r), .i_rd_data(rd_data_r), .o_wr_en(),
      .o_wr_addr(), .o_wr_data(wr_data_r), .o_bank_select(bank_r));

   // memory reads are combinational, writes land on the edge
   assign i_rd_data = mem[o_rd_addr];
   assign rd_data_r = mem[rd_addr_r];
   always @(posedge i_clock) begin
      if (o_wr_en === 1'b1) mem[o_wr_addr] <= o_wr_data;
   end

   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end

   // hang guard, well above the few dozen cycles the run needs
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // inputs move 1 ns after the edge so nothing races the sampling
   task tick();
      @(posedge i_clock);
      #1;
   endtask

   // one copy; valid stays high so callers may chain back to back
   task do_copy(input logic [7:0] f, input logic [4:0] p,
                input logic [7:0] ra, input logic [7:0] wa,
                input logic [7:0] wd);
      i_instr = {dmbs_pkg::COPY_OPC, p, f};
      i_instr_valid = 1'b1;
      #1 check(o_rd_addr, ra);
      tick();
      check({7'h00, o_wr_en}, 8'h01);
      check(o_wr_addr, wa);
      check(o_wr_data, wd);
   endtask

   task idle();
      i_instr_valid = 1'b0;
      tick();
   endtask

   ////////////////////////////////////////////////////////////////////
   task t_copy_plain();
      mem[8'h45] = 8'ha5;
      mem[8'hff] = 8'h69;
      do_copy(8'h45, 5'h1f, 8'h45, 8'h1f, 8'ha5);
      idle();
      check({7'h00, o_wr_en}, 8'h00);
      check(mem[8'h1f], 8'ha5);
      check(mem[8'h45], 8'ha5);
      do_copy(8'hff, 5'h01, 8'hff, 8'h01, 8'h69);
      idle();
   endtask

   task t_indirect();
      i_ptr0 = 8'h77;
      i_ptr1 = 8'h9c;
      mem[8'h77] = 8'h5e;
      mem[8'h9c] = 8'h11;
      do_copy(8'h00, 5'h08, 8'h77, 8'h9c, 8'h5e);
      idle();
      do_copy(8'h08, 5'h00, 8'h9c, 8'h77, 8'h5e);
      idle();
   endtask

   // second copy reads what the first has just written
   task t_back_to_back();
      mem[8'h30] = 8'hc3;
      mem[8'h10] = 8'h00;
      do_copy(8'h30, 5'h10, 8'h30, 8'h10, 8'hc3);
      do_copy(8'h10, 5'h11, 8'h10, 8'h11, 8'hc3);
      idle();
   endtask

   task t_bank();
      mem[8'h20] = 8'h22;
      do_copy(8'h20, 5'h0f, 8'h20, 8'h0f, 8'h22);
      idle();
      check(o_bank_select, 8'h22);
      check(bank_r, 8'h02);
      i_instr = {dmbs_pkg::BANK_OPC, 4'hf, 4'h5};
      i_instr_valid = 1'b1;
      tick();
      check(o_bank_select, 8'h25);
      check(bank_r, 8'h05);
      i_instr = {dmbs_pkg::BANK_OPC, 4'h0, 4'ha};
      idle();
      check(o_bank_select, 8'h25);
      i_instr_valid = 1'b1;
      tick();
      check(o_bank_select, 8'h2a);
      check({7'h00, o_wr_en}, 8'h00);
      // an opcode of neither kind must leave everything alone
      i_instr = 16'hb35a;
      tick();
      check({7'h00, o_wr_en}, 8'h00);
      check(o_bank_select, 8'h2a);
      idle();
   endtask

   // copy into the bank register, then straight out of it: the reduced
   // variant must show its upper nibble as zero despite forwarding
   task t_bank_fwd();
      mem[8'h21] = 8'hb7;
      do_copy(8'h21, 5'h0f, 8'h21, 8'h0f, 8'hb7);
      do_copy(8'h0f, 5'h12, 8'h0f, 8'h12, 8'hb7);
      check(wr_data_r, 8'h07);
      idle();
      check(o_bank_select, 8'hb7);
      check(bank_r, 8'h07);
   endtask

   // reset in mid-run kills the pending write and clears the bank
   task t_reset_mid();
      do_copy(8'h45, 5'h03, 8'h45, 8'h03, 8'ha5);
      i_instr_valid = 1'b0;
      i_sys_rst = 1'b1;
      #1 check({7'h00, o_wr_en}, 8'h00);
      check(o_wr_addr, dmbs_pkg::ADDR_RST);
      check(o_wr_data, dmbs_pkg::DATA_RST);
      check(o_bank_select, dmbs_pkg::BANK_RST);
      check(bank_r, dmbs_pkg::BANK_RST);
      tick();
      tick();
      i_sys_rst = 1'b0;
      do_copy(8'h45, 5'h04, 8'h45, 8'h04, 8'ha5);
      idle();
      check({7'h00, o_wr_en}, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////
   task report_and_stop();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      i_sys_rst = 1'b1;
      i_instr_valid = 1'b0;
      i_instr = 16'h0000;
      i_ptr0 = 8'h00;
      i_ptr1 = 8'h00;
      repeat (12) @(posedge i_clock);
      #1 i_sys_rst = 1'b0;
      check({7'h00, o_wr_en}, 8'h00);
      check(o_bank_select, dmbs_pkg::BANK_RST);
      t_copy_plain();
      t_indirect();
      t_back_to_back();
      t_bank();
      t_bank_fwd();
      t_reset_mid();
      report_and_stop();
   end
endmodule
